// *** rtl/cif_cfg.svh ***
// register indices, field positions, reset values and timing counts
`ifndef CIF_CFG_SVH
`define CIF_CFG_SVH
// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define CIF_IDX_CTRL  8'h00
`define CIF_IDX_STAT  8'h01
`define CIF_IDX_BTIM  8'h03
`define CIF_IDX_BRPE  8'h06
`define CIF_IDX_IFCMD 8'h08
`define CIF_IDX_IFARB 8'h09
`define CIF_IDX_IFMSK 8'h0A
`define CIF_IDX_IFCTL 8'h0B
`define CIF_IDX_IFDA  8'h0C
`define CIF_IDX_IFDB  8'h0D
`define CIF_IDX_FDCTL 8'h26
`define CIF_IDX_FDEND 8'h36
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CIF_CTRL_INIT 0
`define CIF_CTRL_CCE  6
`define CIF_FD_ENA    0
`define CIF_ST_JOIN   1
`define CIF_ST_BUSY   2
`define CIF_ST_TEC    15:8
`define CIF_ST_REC    23:16
`define CIF_CMD_WR    7
`define CIF_CMD_NUM   4:0
`define CIF_ARB_ID    28:0
`define CIF_ARB_XTD   29
`define CIF_ARB_DIR   30
`define CIF_CTL_DLC   3:0
`define CIF_CTL_TXRQ  4
`define CIF_CTL_NEWD  5
`define CIF_CTL_VAL   6
`define CIF_CTL_RMT   7
`define CIF_CTL_UMSK  8
// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define CIF_BTIM_RST  16'h2301
`define CIF_IDLE_BITS 4'hB
`define CIF_MAX_DLC   4'h8
`define CIF_NOBJ      32
`endif

// *** rtl/cif_pkg.sv ***
// types shared by the init and message transfer block
package cif_pkg;
	`include "cif_cfg.svh"
	typedef logic [4:0] cif_num_type; // message object number
	// whole register state of the block
	typedef struct packed {
		logic                            init;     // init request
		logic                            cce;      // config change enable
		logic                            flexible_rate_enable;     // flexible rate enable
		logic                            joined;   // bus idle seen
		logic                            pready;
		logic                            pslverr;
		logic                            can_tx;
		logic                            tx_busy;  // frame handed out
		logic [3:0]                      idle_cnt; // recessive bits seen
		logic [15:0]                     btim;
		logic [3:0]                      brpe;
		logic [7:0]                      tec;
		logic [7:0]                      rec;
		logic [31:0]                     prdata;
		logic [7:0]                      if_cmd;
		logic [31:0]                     if_arb;
		logic [28:0]                     if_msk;
		logic [8:0]                      if_ctl;
		logic [63:0]                     if_dat;
		cif_num_type                     tx_num;
		logic [31:0]                     tx_arb;
		logic [3:0]                      tx_dlc;
		logic                            tx_fd;
		logic [63:0]                     tx_dat;
		logic [`CIF_NOBJ-1:0][31:0]      arb;      // message ram
		logic [`CIF_NOBJ-1:0][28:0]      msk;
		logic [`CIF_NOBJ-1:0][8:0]       ctl;
		logic [`CIF_NOBJ-1:0][63:0]      dat;
	} cif_state_type;
endpackage

// *** rtl/cif_core.sv ***
// init control, acceptance filtering and transmit scheduling
// Functional notes
// [RULE1] init set by write, reset, bus-off
// [RULE2] init stops transfers, tx recessive
// [RULE3] setting init keeps error counters
// [RULE4] setting init keeps configuration registers
// [RULE5] bit timing writes need init and cce
// [RULE6] only cpu clears init; 11 recessive bits
// [RULE7] host programs timing and objects in init
// [RULE8] object config accepted at any time
// [RULE9] host invalidates object before reconfiguring
// [RULE10] accepted frame stored whole in object
// [RULE11] masked id bits overwritten by frame
// [RULE12] host access consistent with bus transfers
// [RULE13] host sets txrq with new_data_flag together
// [RULE14] shared object fully rewritten per send
// [RULE15] many requests sent in priority order
// [RULE16] update before start sends new data
// [RULE17] matching remote frame sets transmit request
// [RULE18] remote frames always in classic format
// [RULE19] data field at most eight bytes
// [RULE20] fd enable writable only init and cce
// [RULE21] 32 objects, each with own mask
// [RULE22] lowest object number wins priority
//
// Implementation choices: the register addresses and the APB slave port.
module cif_core
	import cif_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        can_rx,     // bus level, 1 = recessive
	output logic             can_tx,
	input  wire logic        bit_tick,   // one pulse per sample point
	input  wire logic        core_tx,    // serial bit from the core
	input  wire logic        bus_off,
	input  wire logic        tx_err_inc,
	input  wire logic        rx_err_inc,
	input  wire logic        rx_valid,   // received frame strobe
	input  wire logic [28:0] rx_id,
	input  wire logic        rx_xtd,
	input  wire logic        rx_rtr,
	input  wire logic [3:0]  rx_dlc,
	input  wire logic [63:0] rx_data,
	output logic             tx_valid,   // frame waiting for the core
	output logic      [28:0] tx_id,
	output logic             tx_xtd,
	output logic             tx_rtr,
	output logic             tx_fd,
	output logic      [3:0]  tx_dlc,
	output logic      [63:0] tx_data,
	input  wire logic        tx_done
);
	import cif_pkg::*;
	// ------------------------------------------------------------------
	// state and decode helpers
	// ------------------------------------------------------------------
	cif_state_type         st;       // registered state
	cif_state_type         nxt_st;   // next state
	logic                  act;      // taking part in bus traffic
	logic                  rx_hit;   // acceptance filter matched
	cif_num_type           rx_idx;
	logic                  tx_hit;   // some object pending
	cif_num_type           tx_idx;
	logic [`CIF_NOBJ-1:0]  pend;     // pending transmit requests
	logic                  rx_go;
	logic                  tx_go;
	logic [7:0]            idx;      // word index on the bus
	logic                  wr_acc;   // write committed this edge
	assign act    = !st.init && st.joined;
	assign idx    = paddr[9:2];
	assign wr_acc = psel && penable && st.pready && pwrite;
	assign rx_go  = rx_valid && act && rx_hit;
	assign tx_go  = act && !st.tx_busy && tx_hit && !nxt_st.init;
	// outputs straight from the state flops
	assign prdata   = st.prdata;
	assign pready   = st.pready;
	assign pslverr  = st.pslverr;
	assign can_tx   = st.can_tx;
	assign tx_valid = st.tx_busy;
	assign tx_id    = st.tx_arb[`CIF_ARB_ID];
	assign tx_xtd   = st.tx_arb[`CIF_ARB_XTD];
	assign tx_rtr   = !st.tx_arb[`CIF_ARB_DIR];
	assign tx_fd    = st.tx_fd;
	assign tx_dlc   = st.tx_dlc;
	assign tx_data  = st.tx_dat;
	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [28:0] flt;
		flt    = '0;
		nxt_st = st;
		rx_hit = 1'b0;
		rx_idx = '0;
		tx_hit = 1'b0;
		tx_idx = '0;
		pend   = '0;
		nxt_st.pready  = 1'b0;
		nxt_st.pslverr = 1'b0;
		// counters live on through init, only reset clears them
		if (tx_err_inc)
			nxt_st.tec = st.tec + 8'h01; // RULE3
		if (rx_err_inc)
			nxt_st.rec = st.rec + 8'h01; // RULE3
		// bus idle detection after init is released
		if (st.init) begin
			nxt_st.joined   = 1'b0;
			nxt_st.idle_cnt = '0;
		end else if (!st.joined && bit_tick) begin
			if (!can_rx)
				nxt_st.idle_cnt = '0; // dominant restarts the count
			else if (st.idle_cnt == `CIF_IDLE_BITS - 4'h1)
				nxt_st.joined = 1'b1; // RULE6
			else
				nxt_st.idle_cnt = st.idle_cnt + 4'h1;
		end
		// priority scan, downward so the lowest number wins
		for (int i = `CIF_NOBJ - 1; i >= 0; i--) begin
			flt = st.ctl[i][`CIF_CTL_UMSK] ? st.msk[i] : '1; // RULE21
			if (st.ctl[i][`CIF_CTL_VAL]
			    && st.arb[i][`CIF_ARB_DIR] == rx_rtr
			    && st.arb[i][`CIF_ARB_XTD] == rx_xtd
			    && ((st.arb[i][`CIF_ARB_ID] ^ rx_id) & flt) == '0) begin
				rx_hit = 1'b1;
				rx_idx = cif_num_type'(i);
			end
			pend[i] = st.ctl[i][`CIF_CTL_VAL] && st.ctl[i][`CIF_CTL_TXRQ];
			if (pend[i]) begin
				tx_hit = 1'b1; // RULE22
				tx_idx = cif_num_type'(i);
			end
		end
		// transmit handling; init aborts any frame handed out
		if (!act) begin
			nxt_st.tx_busy = 1'b0; // RULE2
		end else if (st.tx_busy) begin
			if (tx_done) begin
				nxt_st.tx_busy = 1'b0;
				nxt_st.ctl[st.tx_num][`CIF_CTL_TXRQ] = 1'b0;
				nxt_st.ctl[st.tx_num][`CIF_CTL_NEWD] = 1'b0;
			end
		end else if (tx_hit) begin
			// snapshot taken at start, later updates wait for the next
			nxt_st.tx_busy = 1'b1; // RULE15
			nxt_st.tx_num  = tx_idx;
			nxt_st.tx_arb  = st.arb[tx_idx]; // RULE16
			nxt_st.tx_dat  = st.dat[tx_idx];
			nxt_st.tx_dlc  = st.ctl[tx_idx][`CIF_CTL_DLC];
			if (st.ctl[tx_idx][`CIF_CTL_DLC] > `CIF_MAX_DLC)
				nxt_st.tx_dlc = `CIF_MAX_DLC; // RULE19
			// a receive object sends a remote frame, never fd
			nxt_st.tx_fd = st.flexible_rate_enable && st.arb[tx_idx][`CIF_ARB_DIR]; // RULE18
		end
		// reception after the done clear, so a set wins
		if (rx_go) begin
			if (rx_rtr) begin
				if (st.ctl[rx_idx][`CIF_CTL_RMT])
					nxt_st.ctl[rx_idx][`CIF_CTL_TXRQ] = 1'b1; // RULE17
			end else begin
				nxt_st.arb[rx_idx][`CIF_ARB_ID]   = rx_id; // RULE11
				nxt_st.ctl[rx_idx][`CIF_CTL_DLC]  = rx_dlc; // RULE10
				nxt_st.dat[rx_idx]                = rx_data; // RULE10
				nxt_st.ctl[rx_idx][`CIF_CTL_NEWD] = 1'b1;
			end
		end
		// apb read: data prepared while pready rises
		if (psel && penable && !st.pready) begin
			nxt_st.pready = 1'b1;
			nxt_st.prdata = '0;
			if (idx == `CIF_IDX_CTRL) begin
				nxt_st.prdata[`CIF_CTRL_INIT] = st.init;
				nxt_st.prdata[`CIF_CTRL_CCE]  = st.cce;
			end else if (idx == `CIF_IDX_STAT) begin
				nxt_st.prdata[`CIF_CTRL_INIT] = st.init;
				nxt_st.prdata[`CIF_ST_JOIN]   = st.joined;
				nxt_st.prdata[`CIF_ST_BUSY]   = st.tx_busy;
				nxt_st.prdata[`CIF_ST_TEC]    = st.tec;
				nxt_st.prdata[`CIF_ST_REC]    = st.rec;
			end else if (idx == `CIF_IDX_BTIM)
				nxt_st.prdata[15:0] = st.btim;
			else if (idx == `CIF_IDX_BRPE)
				nxt_st.prdata[3:0] = st.brpe;
			else if (idx == `CIF_IDX_IFCMD)
				nxt_st.prdata[7:0] = st.if_cmd;
			else if (idx == `CIF_IDX_IFARB)
				nxt_st.prdata = st.if_arb;
			else if (idx == `CIF_IDX_IFMSK)
				nxt_st.prdata[28:0] = st.if_msk;
			else if (idx == `CIF_IDX_IFCTL)
				nxt_st.prdata[8:0] = st.if_ctl;
			else if (idx == `CIF_IDX_IFDA)
				nxt_st.prdata = st.if_dat[31:0];
			else if (idx == `CIF_IDX_IFDB)
				nxt_st.prdata = st.if_dat[63:32];
			else if (idx == `CIF_IDX_FDCTL)
				nxt_st.prdata[`CIF_FD_ENA] = st.flexible_rate_enable;
			else if (idx > `CIF_IDX_FDCTL && idx <= `CIF_IDX_FDEND)
				nxt_st.prdata = '0; // fd space, reads as zero
			else
				nxt_st.pslverr = 1'b1; // unmapped
		end
		// apb write, taken at the edge that samples pready
		if (wr_acc) begin
			if (idx == `CIF_IDX_CTRL) begin
				nxt_st.init = pwdata[`CIF_CTRL_INIT]; // RULE1 RULE6
				nxt_st.cce  = pwdata[`CIF_CTRL_CCE];
			end else if (idx == `CIF_IDX_BTIM) begin
				if (st.init && st.cce)
					nxt_st.btim = pwdata[15:0]; // RULE5
			end else if (idx == `CIF_IDX_BRPE) begin
				if (st.init && st.cce)
					nxt_st.brpe = pwdata[3:0]; // RULE5
			end else if (idx == `CIF_IDX_FDCTL) begin
				if (st.init && st.cce)
					nxt_st.flexible_rate_enable = pwdata[`CIF_FD_ENA]; // RULE20
			end else if (idx == `CIF_IDX_IFCMD) begin
				// whole object moves in one edge, never half old
				nxt_st.if_cmd = pwdata[7:0];
				if (pwdata[`CIF_CMD_WR]) begin
					nxt_st.arb[pwdata[`CIF_CMD_NUM]] = st.if_arb; // RULE8
					nxt_st.msk[pwdata[`CIF_CMD_NUM]] = st.if_msk; // RULE12
					nxt_st.ctl[pwdata[`CIF_CMD_NUM]] = st.if_ctl;
					nxt_st.dat[pwdata[`CIF_CMD_NUM]] = st.if_dat;
				end else begin
					nxt_st.if_arb = st.arb[pwdata[`CIF_CMD_NUM]]; // RULE12
					nxt_st.if_msk = st.msk[pwdata[`CIF_CMD_NUM]];
					nxt_st.if_ctl = st.ctl[pwdata[`CIF_CMD_NUM]];
					nxt_st.if_dat = st.dat[pwdata[`CIF_CMD_NUM]];
				end
			end else if (idx == `CIF_IDX_IFARB)
				nxt_st.if_arb = {1'b0, pwdata[30:0]};
			else if (idx == `CIF_IDX_IFMSK)
				nxt_st.if_msk = pwdata[28:0];
			else if (idx == `CIF_IDX_IFCTL)
				nxt_st.if_ctl = pwdata[8:0];
			else if (idx == `CIF_IDX_IFDA)
				nxt_st.if_dat[31:0] = pwdata;
			else if (idx == `CIF_IDX_IFDB)
				nxt_st.if_dat[63:32] = pwdata;
		end
		// bus-off forces init and wins over a clearing write
		if (bus_off)
			nxt_st.init = 1'b1; // RULE1
		// init set now aborts tx and holds the pin recessive at once
		if (nxt_st.init)
			nxt_st.tx_busy = 1'b0; // RULE2
		nxt_st.can_tx = (act && !nxt_st.init) ? core_tx : 1'b1; // RULE2
	end
	// ------------------------------------------------------------------
	// state register; config is untouched by init, only by reset
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st        <= '0;
			st.init   <= 1'b1; // RULE1
			st.can_tx <= 1'b1;
			st.btim   <= `CIF_BTIM_RST;
		end else begin
			st <= nxt_st; // RULE4
		end
	end
	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_release;
		$fell(st.init);
	endsequence
	sequence s_gated_wr(logic [7:0] a);
		wr_acc && idx == a && !(st.init && st.cce);
	endsequence
	property p_init_tx;
		st.init |=> can_tx;
	endproperty
	a_init_tx: assert property (p_init_tx) // RULE2
		else $error("tx not recessive during init");
	property p_boff;
		bus_off |=> st.init && !tx_valid;
	endproperty
	a_boff: assert property (p_boff) // RULE1
		else $error("bus-off did not force init");
	property p_tec;
		!tx_err_inc |=> $stable(st.tec);
	endproperty
	a_tec: assert property (p_tec) // RULE3
		else $error("error counter moved without event");
	property p_btim;
		s_gated_wr(`CIF_IDX_BTIM) |=> $stable(st.btim);
	endproperty
	a_btim: assert property (p_btim) // RULE5
		else $error("bit timing written outside init");
	property p_flexible_rate_enable;
		s_gated_wr(`CIF_IDX_FDCTL) |=> $stable(st.flexible_rate_enable);
	endproperty
	a_flexible_rate_enable: assert property (p_flexible_rate_enable) // RULE20
		else $error("fd enable written outside init");
	property p_join;
		s_release |-> !st.joined ##1 !st.joined;
	endproperty
	a_join: assert property (p_join) // RULE6
		else $error("joined bus without idle sequence");
	property p_rx;
		rx_go && !rx_rtr |=>
			st.dat[$past(rx_idx)] == $past(rx_data)
			&& st.ctl[$past(rx_idx)][`CIF_CTL_NEWD];
	endproperty
	a_rx: assert property (p_rx) // RULE10
		else $error("accepted frame not stored");
	property p_rmt;
		rx_go && rx_rtr && st.ctl[rx_idx][`CIF_CTL_RMT] |=>
			st.ctl[$past(rx_idx)][`CIF_CTL_TXRQ];
	endproperty
	a_rmt: assert property (p_rmt) // RULE17
		else $error("remote frame did not set request");
	property p_prio;
		tx_go |-> (pend & ((`CIF_NOBJ'(1) << tx_idx) - `CIF_NOBJ'(1))) == '0
			##1 tx_valid && st.tx_num == $past(tx_idx);
	endproperty
	a_prio: assert property (p_prio) // RULE22
		else $error("transmit order not by priority");
	property p_rtr_fmt;
		tx_valid && tx_rtr |-> !tx_fd && tx_dlc <= `CIF_MAX_DLC;
	endproperty
	a_rtr_fmt: assert property (p_rtr_fmt) // RULE18
		else $error("remote frame sent in fd format");
	property p_dlc;
		tx_valid |-> tx_dlc <= `CIF_MAX_DLC;
	endproperty
	a_dlc: assert property (p_dlc) // RULE19
		else $error("data length above eight bytes");
endmodule // cif_core

// *** tb/cif_far_end.sv ***
// far side model: protocol core bit clock, bus level and frame handshake
module cif_far_end (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       quiet,    // 1 = bus idle, recessive
	input  wire logic [7:0] dly,      // cycles before a frame is done
	input  wire logic       tx_valid,
	output logic            bit_tick = 1'b0,
	output logic            can_rx = 1'b1,
	output logic            core_tx = 1'b1,
	output logic            tx_done = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [1:0] ph_ff = 2'h0;  // bit phase, one tick per four clocks
	logic [7:0] cnt_ff = 8'h0; // cycles spent on the offered frame
	// ticks, bus level and done pulse; busy bus alternates levels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_ff <= 2'h0;
			cnt_ff <= 8'h0;
			bit_tick <= 1'b0;
			can_rx <= 1'b1;
			core_tx <= 1'b1;
			tx_done <= 1'b0;
		end else begin
			ph_ff <= ph_ff + 2'h1;
			bit_tick <= (ph_ff == 2'h3);
			// toggles each cycle so a stale copy is seen
			core_tx <= ~core_tx;
			if (ph_ff == 2'h3) begin
				can_rx <= quiet | ~can_rx;
			end
			tx_done <= 1'b0;
			cnt_ff <= 8'h0;
			// done once per frame; never while nothing is offered
			if (tx_valid && !tx_done && cnt_ff == dly) begin
				tx_done <= 1'b1;
			end else if (tx_valid && !tx_done) begin
				cnt_ff <= cnt_ff + 8'h1;
			end
		end
	end
endmodule // cif_far_end

// *** tb/cif_core_bench.sv ***
// self-checking bench of the init and message transfer block
`include "cif_cfg.svh"
module cif_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, can_rx, can_tx, bit_tick, core_tx;
	logic        bus_off = 0, tx_err_inc = 0, rx_err_inc = 0, rx_valid = 0;
	logic        rx_xtd = 0, rx_rtr = 0, quiet = 0, err;
	logic [28:0] rx_id = 29'h0, tx_id;
	logic [3:0]  rx_dlc = 4'h0, tx_dlc;
	logic [63:0] rx_data = 64'h0, tx_data;
	logic        tx_valid, tx_xtd, tx_rtr, tx_fd, tx_done;
	logic [7:0]  dly = 8'h3C;  // slow first frame, room for updates
	int          mismatches = 0, num_checks = 0;
	always #20 pclk = ~pclk;
	cif_core i_cif_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx),
		.bit_tick(bit_tick), .core_tx(core_tx), .bus_off(bus_off),
		.tx_err_inc(tx_err_inc), .rx_err_inc(rx_err_inc),
		.rx_valid(rx_valid), .rx_id(rx_id), .rx_xtd(rx_xtd),
		.rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_id(tx_id), .tx_xtd(tx_xtd),
		.tx_rtr(tx_rtr), .tx_fd(tx_fd), .tx_dlc(tx_dlc),
		.tx_data(tx_data), .tx_done(tx_done));
	cif_far_end i_cif_far_end (.pclk(pclk), .presetn(presetn),
		.quiet(quiet), .dly(dly), .tx_valid(tx_valid),
		.bit_tick(bit_tick), .can_rx(can_rx), .core_tx(core_tx),
		.tx_done(tx_done));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one apb transfer; waits on pready, bounded
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(pready, 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask
	// whole object through the interface registers
	task objw(input logic [4:0] n, input logic [31:0] a, m, t, da, db);
		apb(1'b1, `CIF_IDX_IFARB, a);
		apb(1'b1, `CIF_IDX_IFMSK, m);
		apb(1'b1, `CIF_IDX_IFCTL, t);
		apb(1'b1, `CIF_IDX_IFDA, da);
		apb(1'b1, `CIF_IDX_IFDB, db);
		apb(1'b1, `CIF_IDX_IFCMD, {24'h0, 3'b100, n});
	endtask
	// one received frame; id and data scrambled once the strobe is gone
	task frame(input logic [28:0] id, input logic rtr, input logic [3:0] dlc,
		input logic [63:0] d);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_rtr <= rtr;
		rx_dlc <= dlc;
		rx_data <= d;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_id <= ~id;
		rx_data <= ~d;
	endtask
	task tx_see(input logic [35:0] hdr);
		int n;
		n = 0;
		while (tx_valid !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk({tx_id, tx_xtd, tx_rtr, tx_fd, tx_dlc}, hdr);
	endtask
	task tx_end;
		int n;
		n = 0;
		while (tx_valid !== 1'b0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk(tx_valid, 1'b0);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`CIF_IDX_CTRL, 32'h1);
		rdc(`CIF_IDX_BTIM, 32'h2301);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1);
		// timing writes refused until cce is set
		apb(1'b1, `CIF_IDX_BTIM, 32'h1234);
		rdc(`CIF_IDX_BTIM, 32'h2301);
		apb(1'b1, `CIF_IDX_FDCTL, 32'h1);
		rdc(`CIF_IDX_FDCTL, 32'h0);
		apb(1'b1, `CIF_IDX_CTRL, 32'h41);
		apb(1'b1, `CIF_IDX_BTIM, 32'h1234);
		rdc(`CIF_IDX_BTIM, 32'h1234);
		apb(1'b1, `CIF_IDX_BRPE, 32'hF);
		rdc(`CIF_IDX_BRPE, 32'hF);
		apb(1'b1, `CIF_IDX_FDCTL, 32'h1);
		rdc(`CIF_IDX_FDCTL, 32'h1);
		objw(5'd1, 32'h40000055, 32'h0, 32'h72, 32'h11223344, 32'h0);
		objw(5'd3, 32'h40000123, 32'h1FFFFFFF, 32'hFF, 32'hA0A1A2A3,
			32'hB0B1B2B3);
		objw(5'd5, 32'h200, 32'h1FFFFF00, 32'h140, 32'h0, 32'h0);
		// a matching frame during init must be dropped
		frame(29'h200, 1'b0, 4'h4, 64'h1);
		apb(1'b1, `CIF_IDX_IFCMD, 32'h5);
		rdc(`CIF_IDX_IFCTL, 32'h140);
		apb(1'b1, `CIF_IDX_CTRL, 32'h0);
		repeat (40) @(posedge pclk);
		rdc(`CIF_IDX_STAT, 32'h0);
		chk(can_tx, 1'b1);
		quiet <= 1'b1;
		repeat (28) @(posedge pclk);
		rdc(`CIF_IDX_STAT, 32'h0);
		tx_see({29'h55, 3'b001, 4'h2});
		chk(tx_data, {32'h0, 32'h11223344});
		// new data while the first frame is still on the bus
		objw(5'd3, 32'h40000123, 32'h1FFFFFFF, 32'hFF, 32'h5A5A5A5A,
			32'hC3C3C3C3);
		tx_end;
		dly <= 8'h02;
		tx_see({29'h123, 3'b001, 4'h8});
		chk(tx_data, {32'hC3C3C3C3, 32'h5A5A5A5A});
		tx_end;
		frame(29'h2AB, 1'b0, 4'h5, 64'h0102030405060708);
		apb(1'b1, `CIF_IDX_IFCMD, 32'h5);
		rdc(`CIF_IDX_IFARB, 32'h2AB);
		rdc(`CIF_IDX_IFCTL, 32'h165);
		rdc(`CIF_IDX_IFDA, 32'h05060708);
		rdc(`CIF_IDX_IFDB, 32'h01020304);
		frame(29'h123, 1'b1, 4'h0, 64'h0);
		tx_see({29'h123, 3'b001, 4'h8});
		tx_end;
		objw(5'd5, 32'h200, 32'h1FFFFF00, 32'h150, 32'h0, 32'h0);
		tx_see({29'h200, 3'b010, 4'h0});
		tx_end;
		// permanent object: new data bytes, then request with new data
		apb(1'b1, `CIF_IDX_IFCMD, 32'h1);
		apb(1'b1, `CIF_IDX_IFDA, 32'h600D0001);
		apb(1'b1, `CIF_IDX_IFCTL, 32'h72);
		apb(1'b1, `CIF_IDX_IFCMD, 32'h81);
		tx_see({29'h55, 3'b001, 4'h2});
		chk(tx_data, {32'h0, 32'h600D0001});
		tx_end;
		// invalid object ignores a matching frame until set valid again
		objw(5'd5, 32'h200, 32'h1FFFFF00, 32'h100, 32'h0, 32'h0);
		frame(29'h2CD, 1'b0, 4'h3, 64'h55);
		apb(1'b1, `CIF_IDX_IFCMD, 32'h5);
		rdc(`CIF_IDX_IFCTL, 32'h100);
		objw(5'd5, 32'h200, 32'h1FFFFF00, 32'h140, 32'h0, 32'h0);
		frame(29'h2CD, 1'b0, 4'h3, 64'h55);
		apb(1'b1, `CIF_IDX_IFCMD, 32'h5);
		rdc(`CIF_IDX_IFCTL, 32'h163);
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			tx_err_inc <= 1'b1;
			rx_err_inc <= (i < 2);
			@(posedge pclk);
			tx_err_inc <= 1'b0;
			rx_err_inc <= 1'b0;
		end
		apb(1'b1, `CIF_IDX_CTRL, 32'h1);
		apb(1'b0, `CIF_IDX_STAT, 32'h0);
		chk(rd[23:8], 16'h0203);
		chk(rd[0], 1'b1);
		rdc(`CIF_IDX_BTIM, 32'h1234);
		rdc(`CIF_IDX_FDCTL, 32'h1);
		apb(1'b1, `CIF_IDX_BTIM, 32'h0);
		rdc(`CIF_IDX_BTIM, 32'h1234);
		apb(1'b1, `CIF_IDX_FDCTL, 32'h0);
		rdc(`CIF_IDX_FDCTL, 32'h1);
		chk(can_tx, 1'b1);
		apb(1'b1, `CIF_IDX_CTRL, 32'h0);
		repeat (60) @(posedge pclk);
		rdc(`CIF_IDX_STAT, 32'h00020302);
		// joined: pin follows the core bit one cycle late
		chk(can_tx, !core_tx);
		@(posedge pclk);
		bus_off <= 1'b1;
		@(posedge pclk);
		bus_off <= 1'b0;
		repeat (20) @(posedge pclk);
		rdc(`CIF_IDX_CTRL, 32'h1);
		close_out;
	end
	// watchdog at 10000 cycles, well beyond the under one thousand the run needs
	initial begin
		#400000;
		mismatches++;
		close_out;
	end
endmodule // cif_core_bench
